// ### sbsp_port.sv
// Purpose: Control port of a pipelined burst SRAM with its array.
// Assumes: Inputs synchronous to clk_sys; output enable may change anytime.
// Notes: Read data appears one cycle after the access address is registered.
`timescale 1ns/10ps
module sbsp_port (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [sbsp_pkg::ADDR_W-1:0] word_address_in,
   input wire logic addr_strobe_ctrl_n,
   input wire logic addr_strobe_cpu_n,
   input wire logic burst_step_n,
   input wire logic chip_sel_n,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_n,
   input wire logic full_width_write_n,
   input wire logic lane_write_gate_n,
   input wire logic lane_a_wr_n,
   input wire logic lane_b_wr_n,
   input wire logic lane_c_wr_n,
   input wire logic lane_d_wr_n,
   input wire logic burst_order_select,
   input wire logic output_drive_n,
   input wire logic snooze_request,
   input wire logic [sbsp_pkg::DATA_W-1:0] data_in,
   output logic [sbsp_pkg::DATA_W-1:0] data_out,
   output logic [sbsp_pkg::LANES-1:0] data_oe,
   output logic powered_down,
   output logic snoozing
);
   logic [sbsp_pkg::DATA_W-1:0] rd_word;
   logic [sbsp_pkg::ADDR_W-1:0] base_addr;
   logic [sbsp_pkg::CNT_W-1:0] burst_cnt;
   sbsp_pkg::sbsp_state_t state;
   logic [sbsp_pkg::LANES-1:0] lane_wr;
   logic [sbsp_pkg::DATA_W-1:0] wr_data;
   logic cpu_start;
   logic ctrl_start;
   logic start;
   logic start_sel;
   logic run;
   logic wr_access;
   logic [sbsp_pkg::CNT_W-1:0] next_cnt;
   logic [sbsp_pkg::ADDR_W-1:0] cur_addr;

   // Burst address from base and count
   function automatic logic [sbsp_pkg::CNT_W-1:0] burst_low(
      input logic [sbsp_pkg::CNT_W-1:0] base,
      input logic [sbsp_pkg::CNT_W-1:0] cnt,
      input logic order_hi);
      if (order_hi)
         burst_low = base ^ cnt;
      else
         burst_low = base + cnt;
   endfunction

   // Snooze freezes address, counter, state, array and data_out; reset still acts and data_oe drops
   assign run = clk_en && !snooze_request;
   assign cpu_start = !addr_strobe_cpu_n && !chip_sel_n;
   assign ctrl_start = !addr_strobe_ctrl_n && !cpu_start;
   assign start = cpu_start || ctrl_start;
   // Selects only looked at when an address loads
   assign start_sel = !chip_sel_n && chip_sel_high && !chip_sel_low_n;
   assign next_cnt = burst_cnt + sbsp_pkg::CNT_STEP;
   // Writes only from a selected controller start or a running burst
   assign wr_access = (ctrl_start && start_sel)
      || (!start && state != sbsp_pkg::SBSP_IDLE);
   assign cur_addr = {base_addr[sbsp_pkg::ADDR_W-1:sbsp_pkg::CNT_W],
      burst_low(base_addr[sbsp_pkg::CNT_W-1:0], burst_cnt, burst_order_select)};

   always_comb
   begin
      lane_wr = '0;
      if (!full_width_write_n)
         lane_wr = '1;
      else if (!lane_write_gate_n)
         lane_wr = ~{lane_d_wr_n, lane_c_wr_n, lane_b_wr_n, lane_a_wr_n};
   end

   // Address and burst counter
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         base_addr <= '0;
         burst_cnt <= sbsp_pkg::CNT_RESET;
      end
      else if (run)
      begin
         if (start)
         begin
            base_addr <= word_address_in;
            burst_cnt <= sbsp_pkg::CNT_RESET;
         end
         else if (!burst_step_n && state != sbsp_pkg::SBSP_IDLE)
            burst_cnt <= next_cnt;
      end
   end

   // Access state; a selected processor start always reads
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         state <= sbsp_pkg::SBSP_IDLE;
      else if (run)
      begin
         if (start && !start_sel)
            state <= sbsp_pkg::SBSP_IDLE;
         else if (cpu_start)
            state <= sbsp_pkg::SBSP_READ;
         else if (ctrl_start)
            state <= (lane_wr != '0) ? sbsp_pkg::SBSP_WRITE : sbsp_pkg::SBSP_READ;
         else if (state != sbsp_pkg::SBSP_IDLE)
            state <= (lane_wr != '0) ? sbsp_pkg::SBSP_WRITE : sbsp_pkg::SBSP_READ;
      end
   end

   // Late write: address, lanes and data registered together, array updated one edge later
   always_ff @(posedge clk_sys)
   begin
      if (run)
         wr_data <= data_in;
   end

   genvar g;
   generate
      for (g = 0; g < sbsp_pkg::LANES; g++)
      begin : g_lane
         // Each lane owns its storage, so lanes never share a driver
         logic [sbsp_pkg::LANE_W-1:0] lane_mem [0:sbsp_pkg::DEPTH-1];
         logic lane_pend;
         always_ff @(posedge clk_sys)
         begin
            if (reset)
               lane_pend <= 1'b0;
            else if (run)
               lane_pend <= lane_wr[g] && wr_access;
         end
         always_ff @(posedge clk_sys)
         begin
            if (run && lane_pend)
               lane_mem[cur_addr] <= wr_data[g*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W];
         end
         assign rd_word[g*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W] = lane_mem[cur_addr];
      end
   endgenerate

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         data_out <= '0;
      else if (run && state == sbsp_pkg::SBSP_READ)
         data_out <= rd_word;
   end

   // Enable is registered per clock; true async drive lives in the pad ring
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         data_oe <= '0;
      else if (clk_en)
         data_oe <= {sbsp_pkg::LANES{!output_drive_n && state == sbsp_pkg::SBSP_READ
            && !snooze_request}};
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         powered_down <= 1'b1;
         snoozing <= 1'b0;
      end
      else if (clk_en)
      begin
         snoozing <= snooze_request;
         if (run && start)
            powered_down <= !start_sel;
      end
   end

   a_step_holds: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && !start && burst_step_n
      |=> $stable(burst_cnt))
      else $error("burst counter moved during wait");

   a_step_moves: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && !start && !burst_step_n && state != sbsp_pkg::SBSP_IDLE
      |=> burst_cnt == $past(next_cnt))
      else $error("burst counter did not advance");

   a_start_loads: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && start
      |=> burst_cnt == sbsp_pkg::CNT_RESET && base_addr == $past(word_address_in))
      else $error("start did not load address");

   a_cpu_reads: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && cpu_start && start_sel
      |=> state == sbsp_pkg::SBSP_READ)
      else $error("processor start did not read");

   a_cpu_ignored: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && chip_sel_n && addr_strobe_ctrl_n
      |=> $stable(base_addr))
      else $error("processor strobe taken while deselected");

   a_desel_down: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && ctrl_start && !start_sel
      |=> powered_down && state == sbsp_pkg::SBSP_IDLE)
      else $error("deselect did not power down");

   a_second_down: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && cpu_start && (!chip_sel_high || chip_sel_low_n)
      |=> powered_down && state == sbsp_pkg::SBSP_IDLE)
      else $error("secondary deselect did not power down");

   a_sel_wakes: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && start && start_sel
      |=> !powered_down)
      else $error("selected start left power down");

   a_cont_ignores: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && !start
      |=> $stable(powered_down))
      else $error("select sampled outside address load");

   a_ctrl_write: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && ctrl_start && start_sel && !full_width_write_n
      |=> state == sbsp_pkg::SBSP_WRITE)
      else $error("controller start did not write");

   a_ctrl_read: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && ctrl_start && start_sel && lane_wr == 4'h0
      |=> state == sbsp_pkg::SBSP_READ)
      else $error("controller start did not read");

   a_cpu_no_write: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && cpu_start
      |-> !wr_access)
      else $error("processor start allowed a write");

   a_snooze_freeze: assert property (@(posedge clk_sys)
      disable iff (reset)
      snooze_request
      |=> $stable(state) && $stable(burst_cnt))
      else $error("state moved in snooze");

   a_snooze_base: assert property (@(posedge clk_sys)
      disable iff (reset)
      snooze_request
      |=> $stable(base_addr) && $stable(powered_down))
      else $error("address moved in snooze");

   a_snooze_flag: assert property (@(posedge clk_sys)
      disable iff (reset)
      clk_en && snooze_request
      |=> snoozing)
      else $error("snooze not flagged");

   a_snooze_dark: assert property (@(posedge clk_sys)
      disable iff (reset)
      clk_en && snooze_request
      |=> data_oe == 4'h0)
      else $error("drivers on in snooze");

   a_oe_off: assert property (@(posedge clk_sys)
      disable iff (reset)
      clk_en && output_drive_n
      |=> data_oe == 4'h0)
      else $error("drivers on while disabled");

   a_oe_on: assert property (@(posedge clk_sys)
      disable iff (reset)
      clk_en && !output_drive_n && !snooze_request && state == sbsp_pkg::SBSP_READ
      |=> data_oe == 4'hf)
      else $error("drivers off during read");

   a_linear_wrap: assert property (@(posedge clk_sys)
      disable iff (reset)
      !burst_order_select
      |-> cur_addr[1:0] == 2'(base_addr[1:0] + burst_cnt))
      else $error("linear order wrong");

   a_interleave: assert property (@(posedge clk_sys)
      disable iff (reset)
      burst_order_select
      |-> cur_addr[1:0] == (base_addr[1:0] ^ burst_cnt))
      else $error("interleaved order wrong");

   a_upper_fixed: assert property (@(posedge clk_sys)
      disable iff (reset)
      run
      |-> cur_addr[sbsp_pkg::ADDR_W-1:sbsp_pkg::CNT_W] == base_addr[sbsp_pkg::ADDR_W-1:sbsp_pkg::CNT_W])
      else $error("upper address moved in burst");

   a_wrap_four: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && !start && !burst_step_n && state != sbsp_pkg::SBSP_IDLE && burst_cnt == 2'h3
      |=> burst_cnt == 2'h0)
      else $error("burst counter did not wrap");

   a_full_write: assert property (@(posedge clk_sys)
      disable iff (reset)
      !full_width_write_n
      |-> lane_wr == 4'hf)
      else $error("full width write not all lanes");

   a_gate_blocks: assert property (@(posedge clk_sys)
      disable iff (reset)
      full_width_write_n && lane_write_gate_n
      |-> lane_wr == 4'h0)
      else $error("lane strobe acted with gate high");

   a_lane_only: assert property (@(posedge clk_sys)
      disable iff (reset)
      full_width_write_n && !lane_write_gate_n && lane_a_wr_n
      |-> !lane_wr[0])
      else $error("unstrobed lane written");

   a_lane_b_sel: assert property (@(posedge clk_sys)
      disable iff (reset)
      full_width_write_n && !lane_write_gate_n && !lane_b_wr_n
      |-> lane_wr[1])
      else $error("strobed lane not written");

   a_write_lands: assert property (@(posedge clk_sys)
      disable iff (reset)
      run && wr_access && lane_wr[0]
      |=> g_lane[0].lane_pend)
      else $error("lane write not queued");

endmodule

// ### sbsp_pkg.sv
// Purpose: Constants and types for the synchronous burst SRAM control port.
// Assumes: x32 configuration with four 8-bit byte lanes, 2-bit burst counter.
// Notes: Array depth kept small; widths fixed.
package sbsp_pkg;
   localparam int ADDR_W = 8;
   localparam int LANE_W = 8;
   localparam int LANES = 4;
   localparam int DATA_W = LANE_W * LANES;
   localparam int DEPTH = 256;
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
   localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
   typedef enum logic [1:0] {SBSP_IDLE, SBSP_READ, SBSP_WRITE} sbsp_state_t;
endpackage

// ### sbsp_host.sv
// Purpose: Host controller model issuing strobed accesses.
// Assumes: One task at a time; changes land just after a rising edge.
// Notes: Data bus flips on every step cycle so stale data never looks valid.
`timescale 1ns/10ps
module sbsp_host (
   input wire logic clk_sys,
   output logic [sbsp_pkg::ADDR_W-1:0] word_address_in,
   output logic addr_strobe_ctrl_n,
   output logic addr_strobe_cpu_n,
   output logic burst_step_n,
   output logic chip_sel_n,
   output logic chip_sel_high,
   output logic chip_sel_low_n,
   output logic full_width_write_n,
   output logic lane_write_gate_n,
   output logic [3:0] lanes_n,
   output logic [sbsp_pkg::DATA_W-1:0] data_in
);
   initial
   begin
      {addr_strobe_cpu_n, addr_strobe_ctrl_n, burst_step_n, chip_sel_n} = 4'hf;
      {chip_sel_high, chip_sel_low_n, full_width_write_n, lane_write_gate_n} = 4'hb;
      {lanes_n, word_address_in, data_in} = '1;
   end
   task automatic req(input logic cpu, input logic [7:0] a, input logic [31:0] d,
      input logic [5:0] wr, input logic [2:0] sel);
      @(posedge clk_sys);
      {addr_strobe_cpu_n, addr_strobe_ctrl_n, burst_step_n} <= cpu ? 3'h3 : 3'h5;
      {chip_sel_n, chip_sel_high, chip_sel_low_n} <= sel;
      {full_width_write_n, lane_write_gate_n, lanes_n} <= wr;
      word_address_in <= a;
      data_in <= d;
   endtask
   // Primary select dropped mid-burst on purpose
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         {addr_strobe_cpu_n, addr_strobe_ctrl_n, burst_step_n, chip_sel_n} <= 4'hd;
         {full_width_write_n, lane_write_gate_n, lanes_n} <= 6'h3f;
         data_in <= ~data_in;
      end
      @(posedge clk_sys);
      {addr_strobe_cpu_n, addr_strobe_ctrl_n, burst_step_n} <= 3'h7;
      {full_width_write_n, lane_write_gate_n, lanes_n} <= 6'h3f;
      data_in <= ~data_in;
   endtask
endmodule

// ### testbench.sv
// Purpose: Self-checking bench for the burst SRAM port.
// Assumes: Read data shows while all lane enables are high.
// Notes: Array held in mem for the four words used.
`timescale 1ns/10ps
module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic order = 1'b0;
   logic drive_n = 1'b0;
   logic snooze = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] addr;
   logic [31:0] din, dout;
   logic [31:0] mem [4];
   logic [3:0] ln, oe;
   logic sc, sp, stp, cs, ch, cl, gw, gt, pd, sz;
   logic [10:0] dsel [6] = '{11'h33f, 11'h17e, 11'h67e, 11'h5bf, 11'h17e, 11'h47f};
   int n_mismatch = 0;
   int total_checks = 0;
   initial forever #12.5 clk_sys = ~clk_sys;
   sbsp_host sbsp_host_i (.clk_sys(clk_sys), .word_address_in(addr), .addr_strobe_ctrl_n(sc),
      .addr_strobe_cpu_n(sp), .burst_step_n(stp), .chip_sel_n(cs), .chip_sel_high(ch),
      .chip_sel_low_n(cl), .full_width_write_n(gw), .lane_write_gate_n(gt), .lanes_n(ln),
      .data_in(din));
   sbsp_port sbsp_port_i (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
      .word_address_in(addr), .addr_strobe_ctrl_n(sc), .addr_strobe_cpu_n(sp),
      .burst_step_n(stp), .chip_sel_n(cs), .chip_sel_high(ch), .chip_sel_low_n(cl),
      .full_width_write_n(gw), .lane_write_gate_n(gt), .lane_a_wr_n(ln[0]),
      .lane_b_wr_n(ln[1]), .lane_c_wr_n(ln[2]), .lane_d_wr_n(ln[3]),
      .burst_order_select(order), .output_drive_n(drive_n), .snooze_request(snooze),
      .data_in(din), .data_out(dout), .data_oe(oe), .powered_down(pd), .snoozing(sz));
   task automatic results();
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic burst(input logic [7:0] a, input logic ilv);
      int k;
      logic [1:0] low;
      fork
         begin
            sbsp_host_i.req(1'b0, a, ~din, 6'h3f, 3'h2);
            sbsp_host_i.step(3);
         end
         begin
            repeat (4) @(negedge clk_sys);
            for (k = 0; k < 8 && oe !== 4'hf; k++)
               @(negedge clk_sys);
            if (oe !== 4'hf)
            begin
               n_mismatch++;
               results();
            end
            for (int i = 0; i < 4; i++)
            begin
               low = ilv ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
               check("burst word", dout, mem[low]);
               @(negedge clk_sys);
            end
            @(posedge clk_sys);
            drive_n <= 1'b1;
            @(posedge clk_sys);
            @(negedge clk_sys);
            check("drive off", {28'h0, oe}, 32'h0);
            @(posedge clk_sys);
            drive_n <= 1'b0;
         end
      join
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         mem[i] = 32'h9e3779b9 * 32'(i + 1);
         sbsp_host_i.req(1'b0, 8'h10 + 8'(i), mem[i], 6'h1f, 3'h2);
         sbsp_host_i.step(0);
      end
      burst(8'h11, 1'b0);
      @(posedge clk_sys);
      {reset, order} <= 2'h3;
      @(posedge clk_sys);
      reset <= 1'b0;
      burst(8'h12, 1'b1);
      sbsp_host_i.req(1'b0, 8'h11, 32'h0, 6'h2d, 3'h2);
      sbsp_host_i.step(0);
      mem[1] = mem[1] & 32'hffff00ff;
      sbsp_host_i.req(1'b0, 8'h12, 32'h0, 6'h30, 3'h2);
      sbsp_host_i.step(0);
      sbsp_host_i.req(1'b1, 8'h13, 32'h0, 6'h1f, 3'h2);
      sbsp_host_i.step(0);
      foreach (dsel[j])
      begin
         sbsp_host_i.req(dsel[j][10], 8'h10, 32'h0, dsel[j][6:1], dsel[j][9:7]);
         sbsp_host_i.step(0);
         @(negedge clk_sys);
         check("power down", {31'h0, pd}, {31'h0, dsel[j][0]});
      end
      @(posedge clk_sys);
      clk_en <= 1'b0;
      sbsp_host_i.req(1'b0, 8'h10, 32'h0, 6'h1f, 3'h2);
      sbsp_host_i.step(0);
      @(negedge clk_sys);
      check("frozen", {31'h0, pd}, 32'h1);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      @(posedge clk_sys);
      snooze <= 1'b1;
      sbsp_host_i.req(1'b0, 8'h10, 32'h0, 6'h1f, 3'h2);
      sbsp_host_i.step(0);
      @(negedge clk_sys);
      check("snooze", {31'h0, sz}, 32'h1);
      @(posedge clk_sys);
      snooze <= 1'b0;
      repeat (2) @(posedge clk_sys);
      burst(8'h10, 1'b1);
      results();
   end
endmodule
